// [rtl/dac_cfg_pkg.sv]
// Constants, field positions, reset values and select encodings of the sync and channel configuration bank.
// Assumes an 8-bit register port with 5-bit addresses, decoded from the serial control port elsewhere.
package dac_cfg_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_SAMPLE_LOW  = 5'h14;
    localparam logic [4:0] ADDR_SAMPLE_HIGH = 5'h15;
    localparam logic [4:0] ADDR_DP_SYNC     = 5'h16;
    localparam logic [4:0] ADDR_FIFO_SYNC   = 5'h17;
    localparam logic [4:0] ADDR_PTR_START   = 5'h18;
    localparam logic [4:0] ADDR_UNUSED_A    = 5'h19;
    localparam logic [4:0] ADDR_SLEEP_BIAS  = 5'h1a;
    localparam logic [4:0] ADDR_COARSE_GAIN = 5'h1b;
    localparam logic [4:0] ADDR_RSVD_B      = 5'h1c;
    localparam logic [4:0] ADDR_RSVD_C      = 5'h1d;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SAMPLE_LOW  = 8'h00;
    localparam logic [7:0] RST_SAMPLE_HIGH = 8'h00;
    localparam logic [7:0] RST_DP_SYNC     = 8'h15;
    localparam logic [7:0] RST_FIFO_SYNC   = 8'h15;
    localparam logic [7:0] RST_PTR_START   = 8'h80;
    localparam logic [7:0] RST_SLEEP_BIAS  = 8'h0e;
    localparam logic [7:0] RST_COARSE_GAIN = 8'hff;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DP_ACC_LSB    = 6;
    localparam int DP_NCO_LSB    = 4;
    localparam int DP_CORR_LSB   = 2;
    localparam int DP_OFS_LSB    = 0;
    localparam int FIFO_SEL_LSB  = 3;
    localparam int AFLAG_BIT     = 2;
    localparam int PTR_START_LSB = 4;
    localparam int IO_THR_BIT    = 7;
    localparam int SLEEP_B_BIT   = 5;
    localparam int SLEEP_A_BIT   = 4;
    localparam int LPF_A_BIT     = 3;
    localparam int LPF_B_BIT     = 2;
    localparam int TRIM_LSB      = 0;
    localparam int GAIN_A_LSB    = 4;
    localparam int GAIN_B_LSB    = 0;

    // ----------------------------------------------------------------
    // Pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int         PIN_COUNT  = 4;
    localparam int         PIN_TXEN   = 0;
    localparam int         PIN_SYNC   = 1;
    localparam int         PIN_MSB_A  = 2;
    localparam int         PIN_MSB_B  = 3;
    localparam logic [3:0] PINS_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Select encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DP_TXEN_FIFO = 2'b00,
        DP_SYNC_FIFO = 2'b01,
        DP_SERIAL    = 2'b10,
        DP_ZERO      = 2'b11
    } dp_sync_e;

    typedef enum logic [2:0] {
        FS_TXEN_PIN = 3'b000,
        FS_SYNC_PIN = 3'b001,
        FS_SERIAL   = 3'b010,
        FS_ZERO_A   = 3'b011,
        FS_MSB_A    = 3'b100,
        FS_MSB_B    = 3'b101,
        FS_ZERO_B   = 3'b110,
        FS_ONE      = 3'b111
    } fifo_sync_e;

    typedef enum logic {
        OS_ARMED = 1'b0,
        OS_FIRED = 1'b1
    } one_shot_e;

endpackage

// [rtl/pin_synchronizer.sv]
// Three-stage synchroniser with agreement filter for the asynchronous pin inputs.
// Assumes the pins are quasi-static relative to clk; a rise counts once stages two and three agree, a fall as soon as they disagree.
`timescale 1ns/1ps

module pin_synchronizer (
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic [dac_cfg_pkg::PIN_COUNT-1:0]   pins_raw,
    output logic      [dac_cfg_pkg::PIN_COUNT-1:0]   pins_stable
);
    import dac_cfg_pkg::*;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] stable;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    always_comb begin
        st_d        = st_q;
        st_d.s1     = pins_raw;
        st_d.s2     = st_q.s1;
        st_d.s3     = st_q.s2;
        st_d.stable = (st_q.s2 & st_q.s3) | (st_q.stable & ~(st_q.s2 ^ st_q.s3));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= {PINS_RESET, PINS_RESET, PINS_RESET, PINS_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_stable = st_q.stable;

endmodule // pin_synchronizer

// [rtl/dac_sync_config.sv]
// Sync source selection and channel configuration register bank for a dual-channel DAC datapath.
// Assumes register accesses arrive as single-cycle strobes from the serial control port decoder.
//
// Summary of operation
// - Hold constant sample upper byte; when enabled drive constant to both channels.
// - Constant sample lower byte comes from its own register one address below.
// - Two-bit sync selectors: txen after FIFO, sync after FIFO, serial sync, zero.
// - Accumulator selector in bits 7:6 chooses the NCO phase accumulator sync.
// - NCO load selector in bits 5:4 chooses NCO load sync, default 01.
// - Correction load selector gates gain/phase loads; offset uses bits 1:0.
// - Three-bit FIFO selector: pins, serial, zero, first MSB transitions, zero, one.
// - MSB transition modes give one sync until reset or a write that changes the selector.
// - Marking bit set uses opposite bus MSB; clear uses transmit enable rising edge.
// - Each FIFO sync loads the 4-bit start value into output position counter.
// - Channel B sleep bit sleeps channel B.
// - Channel A sleep bit sleeps channel A and forces channel B asleep.
// - Four-bit coarse gain per channel, A upper nibble, B lower, reset ones.
`timescale 1ns/1ps

module dac_sync_config (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rd_valid,
    input  wire logic        transmit_enable_pin,
    input  wire logic        sync_pin,
    input  wire logic        channel_a_input_bus_msb,
    input  wire logic        channel_b_input_bus_msb,
    input  wire logic        transmit_enable_pin_fifo_out,
    input  wire logic        sync_fifo_out,
    input  wire logic        serially_written_sync,
    input  wire logic        serial_sample_enable,
    input  wire logic        fifo_read_advance,
    input  wire logic [15:0] dac_a_data_in,
    input  wire logic [15:0] dac_b_data_in,
    output logic      [15:0] dac_a_sample,
    output logic      [15:0] dac_b_sample,
    output logic             nco_accum_sync,
    output logic             nco_load_sync,
    output logic             qmc_corr_load_sync,
    output logic             qmc_offset_load_sync,
    output logic             fifo_sync,
    output logic      [3:0]  fifo_out_pos,
    output logic             a_sample_mark,
    output logic             sleep_a,
    output logic             sleep_b,
    output logic             bias_lpf_a_off,
    output logic             bias_lpf_b_off,
    output logic             io_thresh_1p8,
    output logic      [1:0]  bias_trim,
    output logic      [3:0]  coarse_gain_a,
    output logic      [3:0]  coarse_gain_b
);
    import dac_cfg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  sample_low;
        logic [7:0]  sample_high;
        logic [7:0]  dp_sync;
        logic [7:0]  fifo_sync_sel;
        logic [7:0]  ptr_start;
        logic [7:0]  sleep_bias;
        logic [7:0]  coarse;
        logic [7:0]  rdata;
        logic        rd_valid;
        logic [15:0] dac_a;
        logic [15:0] dac_b;
        logic        nco_acc;
        logic        nco_load;
        logic        corr_load;
        logic        ofs_load;
        logic        fifo_sync;
        logic [3:0]  fifo_pos;
        one_shot_e   shot;
        logic [1:0]  msb_prev;
        logic        txen_prev;
        logic        a_mark;
        logic        sleep_b;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pins_stable;
    logic                 pin_txen;
    logic                 pin_sync;
    logic                 pin_msb_a;
    logic                 pin_msb_b;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic dp_select(input logic [1:0] sel,
                                       input logic       txen,
                                       input logic       sync,
                                       input logic       ser);
        logic res;
        res = 1'b0;
        case (dp_sync_e'(sel))
            DP_TXEN_FIFO: res = txen;
            DP_SYNC_FIFO: res = sync;
            DP_SERIAL:    res = ser;
            default:      res = 1'b0;
        endcase
        return res;
    endfunction

    function automatic logic is_msb_mode(input logic [2:0] sel);
        return (fifo_sync_e'(sel) == FS_MSB_A) || (fifo_sync_e'(sel) == FS_MSB_B);
    endfunction

    function automatic logic [7:0] read_reg(input logic [4:0] addr, input state_s s);
        logic [7:0] v;
        v = READ_ZERO;
        if (addr == ADDR_SAMPLE_LOW) begin
            v = s.sample_low;
        end else if (addr == ADDR_SAMPLE_HIGH) begin
            v = s.sample_high;
        end else if (addr == ADDR_DP_SYNC) begin
            v = s.dp_sync;
        end else if (addr == ADDR_FIFO_SYNC) begin
            v = s.fifo_sync_sel;
        end else if (addr == ADDR_PTR_START) begin
            v = s.ptr_start;
        end else if (addr == ADDR_SLEEP_BIAS) begin
            v = s.sleep_bias;
        end else if (addr == ADDR_COARSE_GAIN) begin
            v = s.coarse;
        end else begin
            v = READ_ZERO;
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pins_raw = {channel_b_input_bus_msb, channel_a_input_bus_msb, sync_pin, transmit_enable_pin};

    pin_synchronizer u_pin_sync (
        .clk         (clk),
        .rst         (rst),
        .pins_raw    (pins_raw),
        .pins_stable (pins_stable)
    );

    assign pin_txen  = pins_stable[PIN_TXEN];
    assign pin_sync  = pins_stable[PIN_SYNC];
    assign pin_msb_a = pins_stable[PIN_MSB_A];
    assign pin_msb_b = pins_stable[PIN_MSB_B];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [2:0] fifo_mode;
    logic [2:0] new_mode;
    logic       sel_msb;
    logic       fifo_src;
    logic       fifo_sel_wr;

    always_comb begin
        st_d        = st_q;
        fifo_mode   = st_q.fifo_sync_sel[FIFO_SEL_LSB +: 3];
        new_mode    = reg_wdata[FIFO_SEL_LSB +: 3];
        fifo_sel_wr = reg_wr_en && (reg_addr == ADDR_FIFO_SYNC);
        sel_msb     = (fifo_sync_e'(fifo_mode) == FS_MSB_B) ? pin_msb_b : pin_msb_a;
        fifo_src    = 1'b0;

        // Register writes; reserved addresses ignore writes.
        if (reg_wr_en) begin
            if (reg_addr == ADDR_SAMPLE_LOW) begin
                st_d.sample_low = reg_wdata;
            end else if (reg_addr == ADDR_SAMPLE_HIGH) begin
                st_d.sample_high = reg_wdata;
            end else if (reg_addr == ADDR_DP_SYNC) begin
                st_d.dp_sync = reg_wdata;
            end else if (reg_addr == ADDR_FIFO_SYNC) begin
                st_d.fifo_sync_sel = reg_wdata;
            end else if (reg_addr == ADDR_PTR_START) begin
                st_d.ptr_start = reg_wdata;
            end else if (reg_addr == ADDR_SLEEP_BIAS) begin
                st_d.sleep_bias = reg_wdata;
            end else if (reg_addr == ADDR_COARSE_GAIN) begin
                st_d.coarse = reg_wdata;
            end
        end

        st_d.rd_valid = reg_rd_en;
        st_d.rdata    = reg_rd_en ? read_reg(reg_addr, st_q) : READ_ZERO;

        // Constant sample replaces the datapath on both channels.
        if (serial_sample_enable) begin
            st_d.dac_a = {st_q.sample_high, st_q.sample_low};
            st_d.dac_b = {st_q.sample_high, st_q.sample_low};
        end else begin
            st_d.dac_a = dac_a_data_in;
            st_d.dac_b = dac_b_data_in;
        end

        // Datapath sync routing.
        st_d.nco_acc   = dp_select(st_q.dp_sync[DP_ACC_LSB +: 2], transmit_enable_pin_fifo_out,
                                   sync_fifo_out, serially_written_sync);
        st_d.nco_load  = dp_select(st_q.dp_sync[DP_NCO_LSB +: 2], transmit_enable_pin_fifo_out,
                                   sync_fifo_out, serially_written_sync);
        st_d.corr_load = dp_select(st_q.dp_sync[DP_CORR_LSB +: 2], transmit_enable_pin_fifo_out,
                                   sync_fifo_out, serially_written_sync);
        st_d.ofs_load  = dp_select(st_q.dp_sync[DP_OFS_LSB +: 2], transmit_enable_pin_fifo_out,
                                   sync_fifo_out, serially_written_sync);

        // FIFO sync source; the MSB modes fire once and then hold off.
        case (fifo_sync_e'(fifo_mode))
            FS_TXEN_PIN: fifo_src = pin_txen;
            FS_SYNC_PIN: fifo_src = pin_sync;
            FS_SERIAL:   fifo_src = serially_written_sync;
            FS_MSB_A,
            FS_MSB_B:    fifo_src = (st_q.shot == OS_ARMED) && (sel_msb != st_q.msb_prev[fifo_mode[0]]);
            FS_ONE:      fifo_src = 1'b1;
            default:     fifo_src = 1'b0;
        endcase

        st_d.msb_prev = {pin_msb_b, pin_msb_a};
        if (is_msb_mode(fifo_mode) && fifo_src) begin
            st_d.shot = OS_FIRED;
        end
        // A write that changes the selector re-arms the one-shot.
        if (fifo_sel_wr && (new_mode != fifo_mode)) begin
            st_d.shot = OS_ARMED;
        end

        st_d.fifo_sync = fifo_src;
        if (fifo_src) begin
            st_d.fifo_pos = st_q.ptr_start[PTR_START_LSB +: 4];
        end else if (fifo_read_advance) begin
            st_d.fifo_pos = 4'(st_q.fifo_pos + 4'h1);
        end

        // A-sample marking.
        st_d.txen_prev = pin_txen;
        if (st_q.fifo_sync_sel[AFLAG_BIT]) begin
            st_d.a_mark = pin_msb_b;
        end else begin
            st_d.a_mark = pin_txen & ~st_q.txen_prev;
        end

        // Channel A sleep drags channel B along.
        st_d.sleep_b = st_d.sleep_bias[SLEEP_B_BIT] | st_d.sleep_bias[SLEEP_A_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q               <= '0;
            st_q.sample_low    <= RST_SAMPLE_LOW;
            st_q.sample_high   <= RST_SAMPLE_HIGH;
            st_q.dp_sync       <= RST_DP_SYNC;
            st_q.fifo_sync_sel <= RST_FIFO_SYNC;
            st_q.ptr_start     <= RST_PTR_START;
            st_q.sleep_bias    <= RST_SLEEP_BIAS;
            st_q.coarse        <= RST_COARSE_GAIN;
            st_q.shot          <= OS_ARMED;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata            = st_q.rdata;
    assign reg_rd_valid         = st_q.rd_valid;
    assign dac_a_sample         = st_q.dac_a;
    assign dac_b_sample         = st_q.dac_b;
    assign nco_accum_sync       = st_q.nco_acc;
    assign nco_load_sync        = st_q.nco_load;
    assign qmc_corr_load_sync   = st_q.corr_load;
    assign qmc_offset_load_sync = st_q.ofs_load;
    assign fifo_sync            = st_q.fifo_sync;
    assign fifo_out_pos         = st_q.fifo_pos;
    assign a_sample_mark        = st_q.a_mark;
    assign sleep_a              = st_q.sleep_bias[SLEEP_A_BIT];
    assign sleep_b              = st_q.sleep_b;
    assign bias_lpf_a_off       = st_q.sleep_bias[LPF_A_BIT];
    assign bias_lpf_b_off       = st_q.sleep_bias[LPF_B_BIT];
    assign io_thresh_1p8        = st_q.sleep_bias[IO_THR_BIT];
    assign bias_trim            = st_q.sleep_bias[TRIM_LSB +: 2];
    assign coarse_gain_a        = st_q.coarse[GAIN_A_LSB +: 4];
    assign coarse_gain_b        = st_q.coarse[GAIN_B_LSB +: 4];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_SAMPLE_CONST: assert property (
        serial_sample_enable |=> (dac_a_sample == $past({st_q.sample_high, st_q.sample_low}))
                                 && (dac_b_sample == dac_a_sample))
        else $error("Constant sample not driven to both channels.");

    AST_SAMPLE_LOW: assert property (
        (reg_wr_en && reg_addr == ADDR_SAMPLE_LOW) ##1 serial_sample_enable
        |=> dac_a_sample[7:0] == $past(reg_wdata, 2))
        else $error("Lower constant byte not taken from its register.");

    AST_DP_ZERO: assert property (
        (st_q.dp_sync[DP_CORR_LSB +: 2] == DP_ZERO) |=> !qmc_corr_load_sync)
        else $error("Zero sync selection produced a load.");

    AST_ACC_SYNC: assert property (
        (st_q.dp_sync[DP_ACC_LSB +: 2] == DP_SYNC_FIFO) |=> nco_accum_sync == $past(sync_fifo_out))
        else $error("Accumulator sync does not follow the FIFO sync.");

    AST_NCO_LOAD: assert property (
        (st_q.dp_sync[DP_NCO_LSB +: 2] == DP_SERIAL)
        |=> nco_load_sync == $past(serially_written_sync))
        else $error("NCO load sync does not follow the serial sync.");

    AST_OFS_LOAD: assert property (
        (st_q.dp_sync[DP_OFS_LSB +: 2] == DP_TXEN_FIFO)
        |=> qmc_offset_load_sync == $past(transmit_enable_pin_fifo_out))
        else $error("Offset load sync does not follow transmit enable.");

    AST_FIFO_ONE: assert property (
        (st_q.fifo_sync_sel[FIFO_SEL_LSB +: 3] == FS_ONE) |=> fifo_sync)
        else $error("Always-one FIFO selection did not sync.");

    AST_ONE_SHOT: assert property (
        (st_q.shot == OS_FIRED) && is_msb_mode(st_q.fifo_sync_sel[FIFO_SEL_LSB +: 3])
        && !(reg_wr_en && reg_addr == ADDR_FIFO_SYNC) |=> !fifo_sync)
        else $error("Second sync after first MSB transition.");

    AST_MARK_MSB: assert property (
        st_q.fifo_sync_sel[AFLAG_BIT] |=> a_sample_mark == $past(pin_msb_b))
        else $error("A-sample mark does not follow the opposite bus MSB.");

    AST_MARK_EDGE: assert property (
        !st_q.fifo_sync_sel[AFLAG_BIT] && pin_txen && !$past(pin_txen) |=> a_sample_mark)
        else $error("A-sample mark missed a transmit enable rising edge.");

    AST_PTR_LOAD: assert property (
        fifo_sync |-> fifo_out_pos == $past(st_q.ptr_start[PTR_START_LSB +: 4]))
        else $error("FIFO position not loaded with start value on sync.");

    AST_SLEEP_B: assert property (
        $rose(st_q.sleep_bias[SLEEP_B_BIT]) |-> sleep_b)
        else $error("Channel B sleep bit did not sleep channel B.");

    AST_SLEEP_A: assert property (
        sleep_a |-> sleep_b)
        else $error("Channel B awake while channel A sleeps.");

    AST_GAIN: assert property (
        (reg_wr_en && reg_addr == ADDR_COARSE_GAIN)
        |=> (coarse_gain_a == $past(reg_wdata[7:4])) && (coarse_gain_b == $past(reg_wdata[3:0])))
        else $error("Coarse gain fields not split into nibbles.");

endmodule // dac_sync_config

// [tb/dac_sync_config_tb.sv]
// Self-checking bench for the sync and channel configuration bank.
// Assumes the bank's own assertions run inside it; pin inputs are held low across the opening reset.
`timescale 1ns/1ps

module dac_sync_config_tb;
    import dac_cfg_pkg::*;
    logic        clk, rst, wr, rd, txp, syp, ma, mb, txf, syf, ser, sen, adv;
    logic [4:0]  addr;
    logic [7:0]  wd, rdata;
    logic [15:0] da, db, sa, sb;
    logic [3:0]  pos, ga, gb;
    logic [1:0]  trim;
    logic        rv, s_acc, s_nco, s_cor, s_ofs, fs, mark, sla, slb, io, lpa, lpb;
    int          miscompares, comparisons, cyc, n, m;
    logic [7:0]  tab [0:9] = '{8'h00, 8'h00, 8'h15, 8'h15, 8'h80, 8'h00, 8'h0e, 8'hff, 8'h00, 8'h00};
    int          fcode [0:5] = '{0, 1, 2, 3, 6, 7};

    dac_sync_config dac_sync_config_i (.clk(clk), .rst(rst), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdata), .reg_rd_valid(rv), .transmit_enable_pin(txp), .sync_pin(syp),
        .channel_a_input_bus_msb(ma), .channel_b_input_bus_msb(mb), .transmit_enable_pin_fifo_out(txf),
        .sync_fifo_out(syf), .serially_written_sync(ser), .serial_sample_enable(sen), .fifo_read_advance(adv),
        .dac_a_data_in(da), .dac_b_data_in(db), .dac_a_sample(sa), .dac_b_sample(sb), .nco_accum_sync(s_acc),
        .nco_load_sync(s_nco), .qmc_corr_load_sync(s_cor), .qmc_offset_load_sync(s_ofs), .fifo_sync(fs),
        .fifo_out_pos(pos), .a_sample_mark(mark), .sleep_a(sla), .sleep_b(slb), .bias_lpf_a_off(lpa),
        .bias_lpf_b_off(lpb), .io_thresh_1p8(io), .bias_trim(trim), .coarse_gain_a(ga), .coarse_gain_b(gb));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wrr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        tick(1);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({15'h0, rv}, 16'h1);
        chk({8'h0, rdata}, {8'h0, e});
    endtask

    task automatic count_fs(input int k);
        n = 0;
        m = 0;
        repeat (k) begin
            tick(1);
            if (fs === 1'b1) n++;
            if (mark === 1'b1) m++;
        end
    endtask

    task automatic close_out;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out;
        end
    end

    initial begin
        {rst, wr, rd, txp, syp, ma, mb, txf, syf, ser, sen, adv} = 12'h800;
        addr = 5'h00; wd = 8'h00; da = 16'h1234; db = 16'hbeef;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(5);
        // --------------------------------------------------------
        // Reset values, reserved and unmapped places
        // --------------------------------------------------------
        for (int i = 0; i < 10; i++) rdc(5'h14 + 5'(i), tab[i]);
        rdc(5'h1f, 8'h00);
        chk({ga, gb, io, lpa, lpb, 3'h0, trim}, 16'hff62);
        wrr(5'h19, 8'hff);
        rdc(5'h19, 8'h00);
        wrr(5'h1b, 8'h3c);
        chk({8'h0, ga, gb}, 16'h003c);
        rdc(5'h1b, 8'h3c);
        $display("registers done");
        // --------------------------------------------------------
        // Constant sample routing
        // --------------------------------------------------------
        wrr(5'h15, 8'ha5);
        wrr(5'h14, 8'h3c);
        @(posedge clk);
        sen <= 1'b1;
        tick(2);
        chk(sa, 16'ha53c);
        chk(sb, 16'ha53c);
        wrr(5'h14, 8'h5a);
        chk(sa, 16'ha55a);
        @(posedge clk);
        sen <= 1'b0;
        tick(2);
        chk(sa, 16'h1234);
        chk(sb, 16'hbeef);
        $display("sample done");
        // --------------------------------------------------------
        // Datapath sync selectors, one source live at a time, then a mixed setting with two sources live
        // --------------------------------------------------------
        for (int c = 0; c < 4; c++) begin
            wrr(5'h16, {4{2'(c)}});
            for (int s = 0; s < 3; s++) begin
                @(posedge clk);
                txf <= (s == 0); syf <= (s == 1); ser <= (s == 2);
                tick(2);
                chk({12'h0, s_acc, s_nco, s_cor, s_ofs}, (c == s) ? 16'hf : 16'h0);
            end
        end
        wrr(5'h16, 8'h1b);
        @(posedge clk);
        txf <= 1'b1;
        syf <= 1'b0;
        ser <= 1'b1;
        tick(2);
        chk({12'h0, s_acc, s_nco, s_cor, s_ofs}, 16'ha);
        $display("datapath sync done");
        // --------------------------------------------------------
        // FIFO sync codes and output position load
        // --------------------------------------------------------
        wrr(5'h18, 8'h50);
        @(posedge clk);
        txp <= 1'b1; syp <= 1'b0; ser <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wrr(5'h17, 8'(fcode[i] << 3));
            tick(6);
            chk({15'h0, fs}, (fcode[i] == 1 || fcode[i] == 3 || fcode[i] == 6) ? 16'h0 : 16'h1);
        end
        chk({12'h0, pos}, 16'h5);
        wrr(5'h17, 8'h18);
        @(posedge clk);
        adv <= 1'b1;
        repeat (3) @(posedge clk);
        adv <= 1'b0;
        tick(2);
        chk({12'h0, pos}, 16'h8);
        @(posedge clk);
        txp <= 1'b0;
        tick(6);
        @(posedge clk);
        txp <= 1'b1;
        count_fs(10);
        chk(16'(m), 16'h1);
        $display("fifo sync done");
        // --------------------------------------------------------
        // One-shot MSB modes, rearm by rewrite, A-sample marking
        // --------------------------------------------------------
        wrr(5'h17, 8'h20);
        tick(6);
        @(posedge clk);
        ma <= 1'b1;
        count_fs(10);
        chk(16'(n), 16'h1);
        @(posedge clk);
        ma <= 1'b0;
        count_fs(10);
        chk(16'(n), 16'h0);
        chk({12'h0, pos}, 16'h5);
        wrr(5'h17, 8'h2c);
        @(posedge clk);
        mb <= 1'b1;
        count_fs(10);
        chk(16'(n), 16'h1);
        chk({15'h0, mark}, 16'h1);
        $display("one-shot done");
        // --------------------------------------------------------
        // Sleep controls
        // --------------------------------------------------------
        wrr(5'h1a, 8'h22);
        chk({14'h0, sla, slb}, 16'h1);
        wrr(5'h1a, 8'h12);
        chk({14'h0, sla, slb}, 16'h3);
        wrr(5'h1a, 8'h02);
        chk({14'h0, sla, slb}, 16'h0);
        rdc(5'h1a, 8'h02);
        wrr(5'h1a, 8'h12);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick(5);
        chk({14'h0, sla, slb}, 16'h0);
        rdc(5'h1a, 8'h0e);
        rdc(5'h1b, 8'hff);
        $display("sleep done");
        close_out;
    end
endmodule // dac_sync_config_tb
